// ===== core/kpi_pkg.sv
// shared constants and carrier types for the key port block
// assumes a 4-bit register bus; address bit 7 picks the data bank
package kpi_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;

    // register-file offsets, seen in either bank
    localparam logic [6:0] OFS_LEVEL = 7'h0f;
    localparam logic [6:0] OFS_PINSEL = 7'h1f;
    localparam logic [6:0] OFS_DIR_1A = 7'h25;
    localparam logic [6:0] OFS_DIR_B = 7'h26;
    localparam logic [6:0] OFS_DIR_E = 7'h27;
    localparam logic [6:0] OFS_GROUP = 7'h37;
    localparam logic [6:0] OFS_EDGE = 7'h3d;
    localparam logic [6:0] OFS_IRQ = 7'h3e;
    localparam logic [6:0] OFS_MASK = 7'h3f;

    // data-memory offsets, bank dependent
    localparam logic [6:0] OFS_PE = 7'h6f;
    localparam logic [6:0] OFS_PA = 7'h70;
    localparam logic [6:0] OFS_PB = 7'h71;
    localparam logic [6:0] OFS_PC = 7'h72;
    localparam logic [6:0] OFS_PD = 7'h73;
    localparam logic OFS_1A_BANK = 1'b1;

    // field positions
    localparam int PINSEL_BIT = 1;
    localparam int GROUP_D_BIT = 3;
    localparam int GROUP_C_BIT = 2;
    localparam int IRQ_BIT = 0;
    localparam int LEVEL_BIT = 0;
    localparam int EDGE_BIT = 0;

    // values after reset
    localparam logic [3:0] RST_DIR_E = 4'h0;
    localparam logic [2:0] RST_DIR_1A = 3'h0;
    localparam logic [3:0] RST_DIR_B = 4'hf;
    localparam logic RST_GROUP_C = 1'b1;
    localparam logic RST_GROUP_D = 1'b1;
    localparam logic [3:0] RST_LATCH = 4'h0;
    localparam logic RST_EDGE = 1'b1;
    localparam logic RST_MASK = 1'b0;
    localparam logic RST_PINSEL = 1'b0;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] wdata;
        logic we;
        logic re;
    } kpi_bus_t;
endpackage : kpi_pkg

// ===== core/kpi_port.sv
// key port block: port data registers, direction control, external irq pin
// assumes pins already synchronous to clk and a master that never overlaps strobes
//
// What this block does
// - select bit routes shared pin to interrupt
// - chosen pin edge sets request flag
// - level flag follows the pin
// - bank and offset pick port data
// - ports B, E, 1A have per-bit direction
// - latch drives pin as soon as output
// - port E direction register, reset all inputs
// - port D switches direction as one group
// - output-mode reads return latch contents
// - group bit three sets port D direction
// - port 1A direction register location
`timescale 1ns/10ps
`default_nettype none
module kpi_port #(
    parameter int DW = kpi_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire kpi_pkg::kpi_bus_t bus,
    output logic [3:0] rdData,
    input wire logic [3:0] portAIn,
    input wire logic [3:0] portBIn,
    output logic [3:0] portBOut,
    output logic [3:0] portBOe,
    input wire logic [3:0] portCIn,
    output logic [3:0] portCOut,
    output logic [3:0] portCOe,
    input wire logic [3:0] portDIn,
    output logic [3:0] portDOut,
    output logic [3:0] portDOe,
    input wire logic [3:0] portEIn,
    output logic [3:0] portEOut,
    output logic [3:0] portEOe,
    input wire logic [2:0] port1AIn,
    output logic [2:0] port1AOut,
    output logic [2:0] port1AOe,
    input wire logic sharedPinIn,
    output logic irq
);

    if (DW != 4) begin : g_width_check
        $error("kpi_port serves only 4-bit data");
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire logic bank = bus.addr[7];
    wire logic [6:0] ofs = bus.addr[6:0];
    wire logic b0 = ~bank;
    wire logic b1 = bank;

    // register-file offsets ignore the bank bit; only the data offsets look at it
    wire logic wPinSel = bus.we && ofs == kpi_pkg::OFS_PINSEL;
    wire logic wDir1A = bus.we && ofs == kpi_pkg::OFS_DIR_1A;
    wire logic wDirB = bus.we && ofs == kpi_pkg::OFS_DIR_B;
    wire logic wDirE = bus.we && ofs == kpi_pkg::OFS_DIR_E;
    wire logic wGroup = bus.we && ofs == kpi_pkg::OFS_GROUP;
    wire logic wEdge = bus.we && ofs == kpi_pkg::OFS_EDGE;
    wire logic wIrq = bus.we && ofs == kpi_pkg::OFS_IRQ;
    wire logic wMask = bus.we && ofs == kpi_pkg::OFS_MASK;
    wire logic wPE = bus.we && b0 && ofs == kpi_pkg::OFS_PE;
    wire logic wPA = bus.we && b0 && ofs == kpi_pkg::OFS_PA;
    wire logic wPB = bus.we && b0 && ofs == kpi_pkg::OFS_PB;
    wire logic wPC = bus.we && b0 && ofs == kpi_pkg::OFS_PC;
    wire logic wPD = bus.we && b0 && ofs == kpi_pkg::OFS_PD;
    wire logic wP1A = bus.we && b1 && ofs == kpi_pkg::OFS_PA;
    wire logic wP1B = bus.we && b1 && ofs == kpi_pkg::OFS_PB;

    ////////////////////////////////////////////////////////////////////////
    // control registers

    // port b and the group ports come out of reset pulling their pins low
    logic pinSel_r;
    logic edgeRise_r;
    logic mask_r;
    logic grpC_r;
    logic grpD_r;
    logic [3:0] dirB_r;
    logic [3:0] dirE_r;
    logic [2:0] dir1A_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSel_r <= kpi_pkg::RST_PINSEL;
            edgeRise_r <= kpi_pkg::RST_EDGE;
            mask_r <= kpi_pkg::RST_MASK;
            grpC_r <= kpi_pkg::RST_GROUP_C;
            grpD_r <= kpi_pkg::RST_GROUP_D;
            dirB_r <= kpi_pkg::RST_DIR_B;
            dirE_r <= kpi_pkg::RST_DIR_E;
            dir1A_r <= kpi_pkg::RST_DIR_1A;
        end else begin
            if (wPinSel) pinSel_r <= bus.wdata[kpi_pkg::PINSEL_BIT];
            if (wEdge) edgeRise_r <= bus.wdata[kpi_pkg::EDGE_BIT];
            if (wMask) mask_r <= bus.wdata[kpi_pkg::IRQ_BIT];
            if (wGroup) grpC_r <= bus.wdata[kpi_pkg::GROUP_C_BIT];
            if (wGroup) grpD_r <= bus.wdata[kpi_pkg::GROUP_D_BIT];
            if (wDirB) dirB_r <= bus.wdata;
            if (wDirE) dirE_r <= bus.wdata;
            if (wDir1A) dir1A_r <= bus.wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latches; written in any mode, so an input-mode write is
    // waiting on the line when the bit turns to output

    logic [3:0] latchA_r;
    logic [3:0] latchB_r;
    logic [3:0] latchC_r;
    logic [3:0] latchD_r;
    logic [3:0] latchE_r;
    logic [2:0] latch1A_r;
    logic latch1B_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latchA_r <= kpi_pkg::RST_LATCH;
            latchB_r <= kpi_pkg::RST_LATCH;
            latchC_r <= kpi_pkg::RST_LATCH;
            latchD_r <= kpi_pkg::RST_LATCH;
            latchE_r <= kpi_pkg::RST_LATCH;
            latch1A_r <= kpi_pkg::RST_LATCH[2:0];
            latch1B_r <= 1'b0;
        end else begin
            if (wPA) latchA_r <= bus.wdata;
            if (wPB) latchB_r <= bus.wdata;
            if (wPC) latchC_r <= bus.wdata;
            if (wPD) latchD_r <= bus.wdata;
            if (wPE) latchE_r <= bus.wdata;
            if (wP1A) latch1A_r <= bus.wdata[2:0];
            if (wP1B) latch1B_r <= bus.wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive; enables come straight from the direction flops so the
    // latch reaches the pin in the same cycle the mode turns to output

    wire logic [3:0] outMaskC = {4{grpC_r}};
    wire logic [3:0] outMaskD = {4{grpD_r}};

    // open-drain ports only ever pull low
    assign portBOut = 4'h0;
    assign portCOut = 4'h0;
    assign portDOut = 4'h0;
    assign portBOe = dirB_r & ~latchB_r;
    assign portCOe = outMaskC & ~latchC_r;
    assign portDOe = outMaskD & ~latchD_r;
    assign portEOut = latchE_r;
    assign portEOe = dirE_r;
    assign port1AOut = latch1A_r;
    assign port1AOe = dir1A_r;

    ////////////////////////////////////////////////////////////////////////
    // external interrupt pin

    // levelPrev_r resets low; a pin held high through reset cannot raise
    // the flag, because the select bit also resets low
    logic levelPrev_r;
    logic irqFlag_r;

    wire logic pinRise = sharedPinIn && !levelPrev_r;
    wire logic pinFall = !sharedPinIn && levelPrev_r;
    wire logic pinEdge = edgeRise_r ? pinRise : pinFall;
    wire logic irqEvent = pinSel_r && pinEdge;
    wire logic irqClear = wIrq && bus.wdata[kpi_pkg::IRQ_BIT];
    // a new edge in the clearing cycle wins
    wire logic irqFlag_nxt = irqEvent || (irqFlag_r && !irqClear);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            levelPrev_r <= 1'b0;
            irqFlag_r <= 1'b0;
        end else begin
            levelPrev_r <= sharedPinIn;
            irqFlag_r <= irqFlag_nxt;
        end
    end

    assign irq = irqFlag_r && mask_r;

    ////////////////////////////////////////////////////////////////////////
    // read path; data stand for exactly one cycle after the strobe

    wire logic [3:0] rdB = (dirB_r & latchB_r) | (~dirB_r & portBIn);
    wire logic [3:0] rdC = (outMaskC & latchC_r) | (~outMaskC & portCIn);
    wire logic [3:0] rdD = (outMaskD & latchD_r) | (~outMaskD & portDIn);
    wire logic [3:0] rdE = (dirE_r & latchE_r) | (~dirE_r & portEIn);
    wire logic [2:0] rd1A = (dir1A_r & latch1A_r) | (~dir1A_r & port1AIn);
    // shared bit reads zero while the pin serves the interrupt
    wire logic rd1B = sharedPinIn && !pinSel_r;

    // reserved bits and unmapped offsets read zero
    logic [3:0] rdMux;
    logic [3:0] rdData_r;

    always_comb begin
        rdMux = 4'h0;
        if (ofs == kpi_pkg::OFS_LEVEL) begin
            rdMux[kpi_pkg::LEVEL_BIT] = sharedPinIn;
        end else if (ofs == kpi_pkg::OFS_PINSEL) begin
            rdMux[kpi_pkg::PINSEL_BIT] = pinSel_r;
        end else if (ofs == kpi_pkg::OFS_DIR_1A) begin
            rdMux = {1'b0, dir1A_r};
        end else if (ofs == kpi_pkg::OFS_DIR_B) begin
            rdMux = dirB_r;
        end else if (ofs == kpi_pkg::OFS_DIR_E) begin
            rdMux = dirE_r;
        end else if (ofs == kpi_pkg::OFS_GROUP) begin
            rdMux[kpi_pkg::GROUP_D_BIT] = grpD_r;
            rdMux[kpi_pkg::GROUP_C_BIT] = grpC_r;
        end else if (ofs == kpi_pkg::OFS_EDGE) begin
            rdMux[kpi_pkg::EDGE_BIT] = edgeRise_r;
        end else if (ofs == kpi_pkg::OFS_IRQ) begin
            rdMux[kpi_pkg::IRQ_BIT] = irqFlag_r;
        end else if (ofs == kpi_pkg::OFS_MASK) begin
            rdMux[kpi_pkg::IRQ_BIT] = mask_r;
        end else if (b0 && ofs == kpi_pkg::OFS_PE) begin
            rdMux = rdE;
        end else if (b0 && ofs == kpi_pkg::OFS_PA) begin
            rdMux = portAIn;
        end else if (b0 && ofs == kpi_pkg::OFS_PB) begin
            rdMux = rdB;
        end else if (b0 && ofs == kpi_pkg::OFS_PC) begin
            rdMux = rdC;
        end else if (b0 && ofs == kpi_pkg::OFS_PD) begin
            rdMux = rdD;
        end else if (b1 && ofs == kpi_pkg::OFS_PA) begin
            rdMux = {1'b0, rd1A};
        end else if (b1 && ofs == kpi_pkg::OFS_PB) begin
            rdMux = {3'h0, rd1B};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= 4'h0;
        end else begin
            rdData_r <= bus.re ? rdMux : 4'h0;
        end
    end

    assign rdData = rdData_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_sel_gates_irq: assert property (
        !pinSel_r |=> !$rose(irqFlag_r)
    ) else $error("irq flag set while pin not selected");

    chk_sel_hides_bit: assert property (
        bus.re && bus.addr == {1'b1, kpi_pkg::OFS_PB} && pinSel_r |=> rdData == 4'h0
    ) else $error("shared bit visible while pin serves the interrupt");

    chk_edge_sets_flag: assert property (
        pinSel_r && !edgeRise_r && $fell(sharedPinIn) |=> irqFlag_r && irq == mask_r
    ) else $error("falling edge missed");

    chk_rise_sets_flag: assert property (
        pinSel_r && edgeRise_r && $rose(sharedPinIn) |=> irqFlag_r
    ) else $error("rising edge missed");

    chk_level_read: assert property (
        bus.re && ofs == kpi_pkg::OFS_LEVEL |=> rdData == {3'h0, $past(sharedPinIn)}
    ) else $error("level flag read wrong");

    chk_read_idle: assert property (
        !bus.re |=> rdData == 4'h0
    ) else $error("read data stood past its cycle");

    chk_bank_select: assert property (
        bus.re && bus.addr == {1'b1, kpi_pkg::OFS_PA} && dir1A_r == 3'h0 |=> rdData == {1'b0, $past(port1AIn)}
    ) else $error("bank 1 port read wrong");

    chk_bit_dir: assert property (
        wDirB |=> dirB_r == $past(bus.wdata) && portBOe == ($past(bus.wdata) & ~latchB_r)
    ) else $error("port b per-bit direction wrong");

    chk_latch_on_out: assert property (
        wDir1A && bus.wdata[0] && !dir1A_r[0] |=> port1AOe[0] && port1AOut[0] == $past(latch1A_r[0])
    ) else $error("latch not driven on turn to output");

    chk_dir_e_reset: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n |-> portEOe == 4'h0
    ) else $error("port e not all inputs in reset");

    chk_dir_e_write: assert property (
        wDirE |=> portEOe == $past(bus.wdata)
    ) else $error("port e direction write lost");

    for (genvar i = 0; i < 4; i++) begin : g_e_bit_chk
        chk_e_bit_out: assert property (
            wDirE && bus.wdata[i] && !dirE_r[i] |=> portEOe[i] && portEOut[i] == $past(latchE_r[i])
        ) else $error("port e bit not driven from latch");
    end

    chk_group_d: assert property (
        wGroup && bus.wdata[kpi_pkg::GROUP_D_BIT] |=> portDOe == ~$past(latchD_r)
    ) else $error("port d not switched as a group");

    chk_latch_read: assert property (
        bus.re && bus.addr == {1'b0, kpi_pkg::OFS_PE} && dirE_r == 4'hf |=> rdData == $past(latchE_r)
    ) else $error("output-mode read not from latch");

    chk_b_latch_read: assert property (
        bus.re && bus.addr == {1'b0, kpi_pkg::OFS_PB} && dirB_r == 4'hf |=> rdData == $past(latchB_r)
    ) else $error("port b output-mode read not from latch");

    chk_c_latch_read: assert property (
        bus.re && bus.addr == {1'b0, kpi_pkg::OFS_PC} && grpC_r |=> rdData == $past(latchC_r)
    ) else $error("port c output-mode read not from latch");

    chk_port_a_pins: assert property (
        bus.re && bus.addr == {1'b0, kpi_pkg::OFS_PA} |=> rdData == $past(portAIn)
    ) else $error("input-only port read not from pins");

    chk_group_bit: assert property (
        wGroup |=> grpD_r == $past(bus.wdata[kpi_pkg::GROUP_D_BIT]) && (grpD_r || portDOe == 4'h0)
    ) else $error("group bit three not taken");

    chk_dir_1a: assert property (
        wDir1A |=> port1AOe == $past(bus.wdata[2:0])
    ) else $error("port 1a direction write lost");

    chk_flag_sticky: assert property (
        irqFlag_r && !irqClear |=> irqFlag_r
    ) else $error("irq flag dropped without clear");

    chk_flag_clear: assert property (
        irqFlag_r && irqClear && !(pinSel_r && ($rose(sharedPinIn) || $fell(sharedPinIn))) |=> !irqFlag_r
    ) else $error("irq flag not cleared by write");

endmodule : kpi_port
`default_nettype wire

// ===== test/tb.sv
// testbench for the key port block: drives the register bus and pins directly
// assumes kpi_pkg is compiled first; read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    kpi_pkg::kpi_bus_t bus = '0;
    logic [3:0] rdData, portAIn = 4'h0, portBIn = 4'h0, portCIn = 4'h0, portDIn = 4'h0, portEIn = 4'h0;
    logic [3:0] portBOut, portBOe, portCOut, portCOe, portDOut, portDOe, portEOut, portEOe;
    logic [2:0] port1AIn = 3'h0, port1AOut, port1AOe;
    logic sharedPinIn = 1'b0, irq;
    int failures = 0;
    int compares = 0;

    always #25 clk = ~clk;

    kpi_port dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdData(rdData), .portAIn(portAIn),
        .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe), .portCIn(portCIn), .portCOut(portCOut),
        .portCOe(portCOe), .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe), .portEIn(portEIn),
        .portEOut(portEOut), .portEOe(portEOe), .port1AIn(port1AIn), .port1AOut(port1AOut),
        .port1AOe(port1AOe), .sharedPinIn(sharedPinIn), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus.we <= 1'b0;
        #1;
    endtask : wr

    // the data are looked at only in the one cycle in which they stand
    task automatic rd(input logic [7:0] a, input logic [3:0] ex, input string nm);
        @(posedge clk);
        bus <= '{addr: a, wdata: 4'h0, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus.re <= 1'b0;
        #1;
        `CHK(nm, ex, rdData)
    endtask : rd

    // edge detection samples the pin against the previous cycle, so allow three cycles after the change
    task automatic pin(input logic v);
        @(posedge clk);
        sharedPinIn <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask : pin

    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h27, 4'h0, "dirE");
        `CHK("eOe", 4'h0, portEOe)
        `CHK("dOe", 4'hf, portDOe)
        `CHK("cOe", 4'hf, portCOe)
        `CHK("bOe", 4'hf, portBOe)
        `CHK("bcdOut", 12'h000, {portBOut, portCOut, portDOut})
        `CHK("irq", 1'b0, irq)
        rd(8'h1f, 4'h0, "pinSelRst");
        rd(8'h3d, 4'h1, "edgeRst");
        rd(8'h71, 4'h0, "bLatchRst");
    endtask : t_reset

    task automatic t_port_c;
        portCIn <= 4'h3;
        wr(8'h72, 4'h5);
        `CHK("cOeOut", 4'ha, portCOe)
        rd(8'h72, 4'h5, "cLatch");
        wr(8'h37, 4'h8);
        `CHK("cOeIn", 4'h0, portCOe)
        rd(8'h72, 4'h3, "cIn");
        rd(8'h37, 4'h8, "group");
    endtask : t_port_c

    task automatic t_port_e;
        portEIn <= 4'h5;
        wr(8'h6f, 4'ha);
        `CHK("eOeIn", 4'h0, portEOe)
        rd(8'h6f, 4'h5, "eIn");
        wr(8'h27, 4'h3);
        `CHK("eOe", 4'h3, portEOe)
        `CHK("eOut", 4'ha, portEOut)
        rd(8'h6f, 4'h6, "eMix");
        wr(8'h27, 4'hf);
        `CHK("eOeAll", 4'hf, portEOe)
        rd(8'h6f, 4'ha, "eLatch");
    endtask : t_port_e

    task automatic t_port_bd;
        wr(8'h26, 4'h5);
        rd(8'h26, 4'h5, "dirB");
        wr(8'h71, 4'h4);
        `CHK("bOe", 4'h1, portBOe)
        portDIn <= 4'h9;
        wr(8'h73, 4'h6);
        `CHK("dOe", 4'h9, portDOe)
        wr(8'h37, 4'h0);
        `CHK("dOeIn", 4'h0, portDOe)
        rd(8'h73, 4'h9, "dIn");
        wr(8'h37, 4'h8);
        `CHK("dOeOut", 4'h9, portDOe)
        rd(8'h37, 4'h8, "groupD");
        rd(8'h73, 4'h6, "dLatch");
    endtask : t_port_bd

    task automatic t_port_1a;
        port1AIn <= 3'h5;
        portAIn <= 4'hc;
        wr(8'hf0, 4'h2);
        rd(8'hf0, 4'h5, "p1aIn");
        wr(8'h25, 4'h3);
        `CHK("p1aOe", 3'h3, port1AOe)
        rd(8'h25, 4'h3, "dir1A");
        `CHK("p1aOut", 3'h2, port1AOut)
        rd(8'hf0, 4'h6, "p1aMix");
        wr(8'h70, 4'h3);
        rd(8'h70, 4'hc, "pA");
        rd(8'h74, 4'h0, "unmapped");
    endtask : t_port_1a

    task automatic t_irq;
        pin(1'b1);
        rd(8'hf1, 4'h1, "p1b");
        rd(8'h3e, 4'h0, "noSel");
        pin(1'b0);
        wr(8'h3f, 4'h1);
        rd(8'h3f, 4'h1, "mask");
        wr(8'h1f, 4'h2);
        rd(8'h1f, 4'h2, "pinSel");
        rd(8'hf1, 4'h0, "p1bSel");
        rd(8'h0f, 4'h0, "lvl0");
        pin(1'b1);
        `CHK("irqRise", 1'b1, irq)
        rd(8'h0f, 4'h1, "lvl1");
        pin(1'b0);
        `CHK("irqHeld", 1'b1, irq)
        wr(8'h3e, 4'h1);
        `CHK("irqClr", 1'b0, irq)
        wr(8'h3d, 4'h0);
        pin(1'b1);
        `CHK("noFall", 1'b0, irq)
        pin(1'b0);
        `CHK("irqFall", 1'b1, irq)
        wr(8'h3f, 4'h0);
        `CHK("masked", 1'b0, irq)
        rd(8'h3e, 4'h1, "flag");
        wr(8'h3f, 4'h1);
        pin(1'b1);
        // a falling edge lands in the very cycle that the clear is taken
        @(posedge clk);
        bus <= '{addr: 8'h3e, wdata: 4'h1, we: 1'b1, re: 1'b0};
        sharedPinIn <= 1'b0;
        @(posedge clk);
        bus.we <= 1'b0;
        #1;
        `CHK("setWins", 1'b1, irq)
        wr(8'h3e, 4'h1);
        `CHK("cleared", 1'b0, irq)
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_port_c();
        t_port_e();
        t_port_bd();
        t_port_1a();
        t_irq();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        summarize();
    end

    // cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : tb
`default_nettype wire
